/* pkg/ccp_pkg.sv */
/*
  Constants and helper functions for the codec channel power control block:
  register offsets, field positions, reset values and channel mapping helpers.
  Assumes an 8-bit register port driven by the device's control interface logic.
*/
package ccp_pkg;

  // ****************************************
  // channel geometry
  // ****************************************
  localparam int CCP_NCH = 4;
  localparam int CCP_DYN_PAIR = 2;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] CCP_ADDR_DYN = 8'h77;
  localparam logic [7:0] CCP_ADDR_PWR = 8'h78;
  localparam logic [7:0] CCP_ADDR_STS = 8'h79;
  localparam logic [7:0] CCP_DYN_RESET = 8'h00;
  localparam logic [7:0] CCP_PWR_RESET = 8'h00;
  // reserved bits are cleared in the masks so they always read zero
  localparam logic [7:0] CCP_DYN_WMASK = 8'hfb;
  localparam logic [7:0] CCP_PWR_WMASK = 8'hee;
  localparam logic [7:0] CCP_RDATA_NONE = 8'h00;

  // dynamic_power_config fields
  localparam int CCP_DYN_REC_EN = 7;
  localparam int CCP_DYN_REC_RANGE = 6;
  localparam int CCP_DYN_PLAY_EN = 5;
  localparam int CCP_DYN_PLAY_RANGE = 4;
  localparam int CCP_DYN_SPLIT_CLK = 3;
  localparam int CCP_DYN_RSVD = 2;
  localparam int CCP_DYN_REC_SWAP = 1;
  localparam int CCP_DYN_PLAY_SWAP = 0;

  // power_control fields
  localparam int CCP_PWR_REC_ON = 7;
  localparam int CCP_PWR_PLAY_ON = 6;
  localparam int CCP_PWR_MICBIAS = 5;
  localparam int CCP_PWR_RSVD_HI = 4;
  localparam int CCP_PWR_US_DET = 3;
  localparam int CCP_PWR_VOICE_DET = 2;
  localparam int CCP_PWR_US_ALT_DET = 1;
  localparam int CCP_PWR_RSVD_LO = 0;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [CCP_NCH-1:0] ccp_range_mask(input logic wide);
    logic [CCP_NCH-1:0] m;
    m = '0;
    for (int i = 0; i < CCP_NCH; i++) begin
      if (wide || (i < CCP_DYN_PAIR)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : ccp_range_mask

  function automatic logic [CCP_NCH-1:0] ccp_swap12(input logic [CCP_NCH-1:0] v, input logic swap);
    logic [CCP_NCH-1:0] r;
    r = v;
    if (swap) begin
      r[0] = v[1];
      r[1] = v[0];
    end
    return r;
  endfunction : ccp_swap12

  // status packs channel 1 into the highest bit of its nibble
  function automatic logic [CCP_NCH-1:0] ccp_rev(input logic [CCP_NCH-1:0] v);
    logic [CCP_NCH-1:0] r;
    r = '0;
    for (int i = 0; i < CCP_NCH; i++) begin
      r[CCP_NCH-1-i] = v[i];
    end
    return r;
  endfunction : ccp_rev

endpackage : ccp_pkg

/* pkg/ccp_path_if.sv */
/*
  Carrier between the register logic and one channel power path
  (record or playback). Assumes clk and reset_n from the top module.
*/
`timescale 1ns/1ps
interface ccp_path_if
  import ccp_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n
);
  logic power_on;
  logic dyn_en;
  logic range_sel;
  logic swap;
  logic [CCP_NCH-1:0] channel_enable_reg;
  logic [CCP_NCH-1:0] ch_pwr;
  logic [CCP_NCH-1:0] drive;

  modport ctl (output power_on, output dyn_en, output range_sel, output swap, output channel_enable_reg,
               input ch_pwr, input drive);
  modport path (input clk, input reset_n, input power_on, input dyn_en, input range_sel,
                input swap, input channel_enable_reg, output ch_pwr, output drive);
endinterface : ccp_path_if

/* verilog/ccp_path_power.sv */
/*
  Power state of one channel group (four channels) plus its swapped drive.
  Assumes the enables and controls come from logic on the same clock.
*/
`timescale 1ns/1ps
module ccp_path_power
  import ccp_pkg::*;
(
  // group link
  ccp_path_if.path p
);

  // ****************************************
  // next power state
  // ****************************************
  logic [CCP_NCH-1:0] pwr_q;
  logic [CCP_NCH-1:0] pwr_d;
  logic [CCP_NCH-1:0] drive_q;
  logic [CCP_NCH-1:0] dyn_mask;
  logic [CCP_NCH-1:0] dyn_next;
  logic active;

  assign active = |pwr_q;
  assign dyn_mask = ccp_range_mask(p.range_sel); // RULE2 RULE4
  // channels outside the dynamic range keep their state while streaming
  assign dyn_next = (p.channel_enable_reg & dyn_mask) | (pwr_q & ~dyn_mask); // RULE1 RULE3
  // a channel comes up only when enabled; all drop when power is off
  assign pwr_d = !p.power_on ? '0 : // RULE9 RULE10
                 !active ? p.channel_enable_reg : // RULE17
                 p.dyn_en ? dyn_next : // RULE1 RULE3
                 pwr_q; // RULE1 RULE3

  always_ff @(posedge p.clk or negedge p.reset_n) begin
    if (!p.reset_n) begin
      pwr_q <= '0;
      drive_q <= '0;
    end else begin
      pwr_q <= pwr_d;
      drive_q <= ccp_swap12(pwr_d, p.swap); // RULE6 RULE7 RULE19
    end
  end

  assign p.ch_pwr = pwr_q;
  assign p.drive = drive_q;

endmodule : ccp_path_power

/* verilog/ccp_power_ctrl.sv */
/*
  Channel power control for the record and playback paths of an audio codec:
  the dynamic power and power control registers, status readback, and the
  per-channel power drive. Assumes a register port from the device's control
  interface on the same clock, and channel enables from the channel enable
  register held elsewhere on the same clock.
*/
`timescale 1ns/1ps

// Operation
// RULE1 - record changes refused while active unless dynamic
// RULE2 - record dynamic range: channels 1-2 or 1-4
// RULE3 - playback changes refused while active unless dynamic
// RULE4 - playback dynamic range: channels 1-2 or 1-4
// RULE5 - bit 3 flags differing modulator and mic clocks
// RULE6 - record swap exchanges record channels 1, 2
// RULE7 - playback swap exchanges playback channels 1, 2
// RULE8 - reserved bits read zero, write reset value
// RULE9 - record power bit gates enabled record channels
// RULE10 - playback power bit gates enabled playback channels
// RULE11 - bit 5 powers microphone bias
// RULE12 - bit 3 enables ultrasound detection
// RULE13 - bit 2 enables voice detection
// RULE14 - bit 1 enables alternate ultrasound detection
// RULE15 - dynamic power register resets to zero
// RULE16 - power control register resets to zero
// RULE17 - channel enables choose which channels come up
// RULE18 - read-only status shows each channel's power
// RULE19 - cleared swap bit passes channels straight through
module ccp_power_ctrl
  import ccp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  // channel enables
  input wire logic [CCP_NCH-1:0] in_channel_enable_reg,
  input wire logic [CCP_NCH-1:0] out_channel_enable_reg,
  // channel power drive
  output logic [CCP_NCH-1:0] record_drive,
  output logic [CCP_NCH-1:0] playback_drive,
  output logic [CCP_NCH-1:0] record_status,
  output logic [CCP_NCH-1:0] playback_status,
  // analog and detector controls
  output logic dynamic_split_clock_sel,
  output logic mic_bias_power_on,
  output logic ultrasound_detect_en,
  output logic voice_detect_en,
  output logic ultrasound_detect_alt_en
);

  // ****************************************
  // register decode
  // ****************************************
  logic [7:0] dyn_cfg_q;
  logic [7:0] dyn_cfg_d;
  logic [7:0] pwr_ctl_q;
  logic [7:0] pwr_ctl_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic hit_dyn;
  logic hit_pwr;
  logic hit_sts;
  logic [7:0] status_word;
  ccp_path_if rec_if (.clk(clk), .reset_n(reset_n));
  ccp_path_if play_if (.clk(clk), .reset_n(reset_n));

  assign hit_dyn = (reg_addr == CCP_ADDR_DYN);
  assign hit_pwr = (reg_addr == CCP_ADDR_PWR);
  assign hit_sts = (reg_addr == CCP_ADDR_STS);

  // reserved positions are masked off, so a stray one is never stored
  assign dyn_cfg_d = (reg_we && hit_dyn) ? (reg_wdata & CCP_DYN_WMASK) : dyn_cfg_q; // RULE8
  assign pwr_ctl_d = (reg_we && hit_pwr) ? (reg_wdata & CCP_PWR_WMASK) : pwr_ctl_q; // RULE8

  // status is read-only; writes to its offset are dropped
  assign status_word = {ccp_rev(rec_if.ch_pwr), ccp_rev(play_if.ch_pwr)}; // RULE18

  assign rdata_d = hit_dyn ? dyn_cfg_q :
                   hit_pwr ? pwr_ctl_q :
                   hit_sts ? status_word : // RULE18
                   CCP_RDATA_NONE;

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dyn_cfg_q <= CCP_DYN_RESET; // RULE15
      pwr_ctl_q <= CCP_PWR_RESET; // RULE16
    end else begin
      dyn_cfg_q <= dyn_cfg_d;
      pwr_ctl_q <= pwr_ctl_d;
    end
  end

  // read data holds between reads so a slow master can sample it late
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= CCP_RDATA_NONE;
    end else if (reg_re) begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ****************************************
  // channel groups
  // ****************************************
  assign rec_if.power_on = pwr_ctl_q[CCP_PWR_REC_ON]; // RULE9
  assign rec_if.dyn_en = dyn_cfg_q[CCP_DYN_REC_EN]; // RULE1
  assign rec_if.range_sel = dyn_cfg_q[CCP_DYN_REC_RANGE]; // RULE2
  assign rec_if.swap = dyn_cfg_q[CCP_DYN_REC_SWAP]; // RULE6
  assign rec_if.channel_enable_reg = in_channel_enable_reg; // RULE17

  assign play_if.power_on = pwr_ctl_q[CCP_PWR_PLAY_ON]; // RULE10
  assign play_if.dyn_en = dyn_cfg_q[CCP_DYN_PLAY_EN]; // RULE3
  assign play_if.range_sel = dyn_cfg_q[CCP_DYN_PLAY_RANGE]; // RULE4
  assign play_if.swap = dyn_cfg_q[CCP_DYN_PLAY_SWAP]; // RULE7
  assign play_if.channel_enable_reg = out_channel_enable_reg; // RULE17

  ccp_path_power u_rec (.p(rec_if.path));
  ccp_path_power u_play (.p(play_if.path));

  // ****************************************
  // outputs
  // ****************************************
  assign record_drive = rec_if.drive;
  assign playback_drive = play_if.drive;
  assign record_status = rec_if.ch_pwr; // RULE18
  assign playback_status = play_if.ch_pwr; // RULE18
  // the clocking hint only steers analog clocking outside this block
  assign dynamic_split_clock_sel = dyn_cfg_q[CCP_DYN_SPLIT_CLK]; // RULE5
  assign mic_bias_power_on = pwr_ctl_q[CCP_PWR_MICBIAS]; // RULE11
  assign ultrasound_detect_en = pwr_ctl_q[CCP_PWR_US_DET]; // RULE12
  assign voice_detect_en = pwr_ctl_q[CCP_PWR_VOICE_DET]; // RULE13
  assign ultrasound_detect_alt_en = pwr_ctl_q[CCP_PWR_US_ALT_DET]; // RULE14

  // ****************************************
  // checks
  // ****************************************
  logic rec_frozen;
  logic play_frozen;
  logic rec_dyn;
  logic play_dyn;

  assign rec_frozen = rec_if.power_on && (|record_status) && !rec_if.dyn_en;
  assign play_frozen = play_if.power_on && (|playback_status) && !play_if.dyn_en;
  assign rec_dyn = rec_if.power_on && (|record_status) && rec_if.dyn_en;
  assign play_dyn = play_if.power_on && (|playback_status) && play_if.dyn_en;

  property p_rec_refuse;
    @(posedge clk) disable iff (!reset_n)
    (rec_frozen && rec_if.power_on) ##1 rec_if.power_on |-> record_status == $past(record_status);
  endproperty
  a_rec_refuse: assert property (p_rec_refuse) else $error("record state changed while frozen"); // RULE1

  property p_rec_dyn_follow;
    @(posedge clk) disable iff (!reset_n)
    rec_dyn |=> (record_status & ccp_range_mask($past(rec_if.range_sel)))
                == ($past(in_channel_enable_reg) & ccp_range_mask($past(rec_if.range_sel)));
  endproperty
  a_rec_dyn_follow: assert property (p_rec_dyn_follow) else $error("record channel missed its enable"); // RULE1

  property p_rec_range_narrow;
    @(posedge clk) disable iff (!reset_n)
    (rec_dyn && !rec_if.range_sel) |=> record_status[3:2] == $past(record_status[3:2]);
  endproperty
  a_rec_range_narrow: assert property (p_rec_range_narrow) else $error("record channel 3/4 moved"); // RULE2

  property p_play_refuse;
    @(posedge clk) disable iff (!reset_n)
    play_frozen |=> playback_status == $past(playback_status);
  endproperty
  a_play_refuse: assert property (p_play_refuse) else $error("playback state changed while frozen"); // RULE3

  property p_play_range;
    @(posedge clk) disable iff (!reset_n)
    (play_dyn && !play_if.range_sel) |=>
      playback_status == {$past(playback_status[3:2]), $past(out_channel_enable_reg[1:0])};
  endproperty
  a_play_range: assert property (p_play_range) else $error("playback dynamic range wrong"); // RULE4

  property p_rec_off;
    @(posedge clk) disable iff (!reset_n)
    !rec_if.power_on |=> record_status == '0 && record_drive == '0;
  endproperty
  a_rec_off: assert property (p_rec_off) else $error("record not powered down"); // RULE9

  property p_play_off;
    @(posedge clk) disable iff (!reset_n)
    (!play_if.power_on)[*2] |=> playback_drive == '0;
  endproperty
  a_play_off: assert property (p_play_off) else $error("playback not powered down"); // RULE10

  property p_rec_swap;
    @(posedge clk) disable iff (!reset_n)
    ##1 record_drive == ccp_swap12(record_status, $past(rec_if.swap));
  endproperty
  a_rec_swap: assert property (p_rec_swap) else $error("record swap mapping wrong"); // RULE6

  property p_play_swap;
    @(posedge clk) disable iff (!reset_n)
    $past(play_if.swap) == 1'b0 |-> playback_drive == playback_status;
  endproperty
  a_play_swap: assert property (p_play_swap) else $error("playback pass-through wrong"); // RULE7

  property p_reserved_zero;
    @(posedge clk) disable iff (!reset_n)
    (reg_re && (hit_dyn || hit_pwr)) |=>
      !($past(hit_dyn) && reg_rdata[CCP_DYN_RSVD])
      && !($past(hit_pwr) && (reg_rdata[CCP_PWR_RSVD_HI] || reg_rdata[CCP_PWR_RSVD_LO]));
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read as one"); // RULE8

  property p_pwr_write;
    @(posedge clk) disable iff (!reset_n)
    (reg_we && hit_pwr) |=> mic_bias_power_on == $past(reg_wdata[CCP_PWR_MICBIAS])
      && ultrasound_detect_en == $past(reg_wdata[CCP_PWR_US_DET])
      && voice_detect_en == $past(reg_wdata[CCP_PWR_VOICE_DET])
      && ultrasound_detect_alt_en == $past(reg_wdata[CCP_PWR_US_ALT_DET]);
  endproperty
  a_pwr_write: assert property (p_pwr_write) else $error("power control write not applied"); // RULE11

  property p_split_clk;
    @(posedge clk) disable iff (!reset_n)
    (reg_we && hit_dyn) |=> dynamic_split_clock_sel == $past(reg_wdata[CCP_DYN_SPLIT_CLK]);
  endproperty
  a_split_clk: assert property (p_split_clk) else $error("clock hint not applied"); // RULE5

  property p_powerup_enabled;
    @(posedge clk) disable iff (!reset_n)
    (rec_if.power_on && record_status == '0) |=> record_status == $past(in_channel_enable_reg);
  endproperty
  a_powerup_enabled: assert property (p_powerup_enabled) else $error("wrong channels powered up"); // RULE17

  property p_status_read;
    @(posedge clk) disable iff (!reset_n)
    (reg_re && hit_sts) |=> reg_rdata == {ccp_rev($past(record_status)), ccp_rev($past(playback_status))};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status readback wrong"); // RULE18

  c_rec_dynamic: cover property (@(posedge clk) disable iff (!reset_n)
    rec_dyn ##1 record_status != $past(record_status));
  c_play_refused: cover property (@(posedge clk) disable iff (!reset_n)
    play_frozen && (out_channel_enable_reg != playback_status));
  c_rec_swapped: cover property (@(posedge clk) disable iff (!reset_n)
    rec_if.swap && record_status[0] && !record_status[1]);
  c_status_read: cover property (@(posedge clk) disable iff (!reset_n)
    reg_re && hit_sts && (|status_word));

endmodule : ccp_power_ctrl

/* verification/ccp_power_ctrl_tb_top.sv */
/*
  Self-checking testbench for the codec channel power control block:
  register reset values, reserved bits, detector and bias controls, and the
  record and playback power paths (refusal, dynamic range, swap, status).
  Assumes a register port whose strobes are taken on the rising edge, with
  read data standing one cycle after the read strobe.
*/
`timescale 1ns/1ps
module ccp_power_ctrl_tb_top;
  import ccp_pkg::*;

  // ****************************************
  // signals
  // ****************************************
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [7:0] reg_rdata;
  logic [CCP_NCH-1:0] in_channel_enable_reg = 4'h0;
  logic [CCP_NCH-1:0] out_channel_enable_reg = 4'h0;
  logic [CCP_NCH-1:0] record_drive;
  logic [CCP_NCH-1:0] playback_drive;
  logic [CCP_NCH-1:0] record_status;
  logic [CCP_NCH-1:0] playback_status;
  logic dynamic_split_clock_sel;
  logic mic_bias_power_on;
  logic ultrasound_detect_en;
  logic voice_detect_en;
  logic ultrasound_detect_alt_en;
  int bad_count = 0;
  int n_compared = 0;

  always #5 clk = ~clk;

  ccp_power_ctrl dut (
    .clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .in_channel_enable_reg(in_channel_enable_reg), .out_channel_enable_reg(out_channel_enable_reg),
    .record_drive(record_drive), .playback_drive(playback_drive),
    .record_status(record_status), .playback_status(playback_status),
    .dynamic_split_clock_sel(dynamic_split_clock_sel), .mic_bias_power_on(mic_bias_power_on),
    .ultrasound_detect_en(ultrasound_detect_en), .voice_detect_en(voice_detect_en),
    .ultrasound_detect_alt_en(ultrasound_detect_alt_en)
  );

  // ****************************************
  // tasks
  // ****************************************
  task automatic wrap_up();
    if (bad_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check8

  task automatic check4(input string what, input logic [3:0] exp, input logic [3:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask : check4

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : wr

  // read data is taken a full cycle after the strobe edge, where it stands
  task automatic rd_check(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    idle(1);
    check8(what, exp, reg_rdata);
  endtask : rd_check

  task automatic set_en(input logic play, input logic [3:0] v);
    @(posedge clk);
    if (play) begin
      out_channel_enable_reg <= v;
    end else begin
      in_channel_enable_reg <= v;
    end
  endtask : set_en

  function automatic logic [3:0] st(input logic play);
    return play ? playback_status : record_status;
  endfunction : st

  function automatic logic [3:0] drv(input logic play);
    return play ? playback_drive : record_drive;
  endfunction : drv

  // one power path; record uses bits 7/6/1 of the dynamic register, playback 5/4/0
  task automatic run_path(input logic play);
    logic [7:0] pon;
    logic [7:0] den;
    logic [7:0] rng;
    logic [7:0] swp;
    pon = play ? 8'h40 : 8'h80;
    den = play ? 8'h20 : 8'h80;
    rng = play ? 8'h10 : 8'h40;
    swp = play ? 8'h01 : 8'h02;
    set_en(play, 4'b0011);
    wr(CCP_ADDR_PWR, pon);
    idle(3);
    check4("status power on", 4'b0011, st(play));
    check4("drive no swap", 4'b0011, drv(play));
    rd_check("status register", CCP_ADDR_STS, play ? 8'h0c : 8'hc0);
    set_en(play, 4'b0111);
    idle(3);
    check4("status frozen", 4'b0011, st(play));
    wr(CCP_ADDR_PWR, 8'h00);
    idle(3);
    check4("status power off", 4'b0000, st(play));
    set_en(play, 4'b0011);
    wr(CCP_ADDR_DYN, den);
    wr(CCP_ADDR_PWR, pon);
    set_en(play, 4'b1101);
    idle(3);
    check4("status narrow range", 4'b0001, st(play));
    wr(CCP_ADDR_DYN, den | rng);
    idle(3);
    check4("status wide range", 4'b1101, st(play));
    wr(CCP_ADDR_DYN, den | rng | swp);
    idle(3);
    check4("drive swapped", 4'b1110, drv(play));
    check4("status logical", 4'b1101, st(play));
    wr(CCP_ADDR_PWR, 8'h00);
    wr(CCP_ADDR_DYN, 8'h00);
    set_en(play, 4'b0000);
    idle(3);
    check4("drive after off", 4'b0000, drv(play));
  endtask : run_path

  // ****************************************
  // tests
  // ****************************************
  initial begin
    logic [7:0] e;
    int bits [4] = '{5, 3, 2, 1};
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    idle(1);
    rd_check("dynamic reset", CCP_ADDR_DYN, 8'h00);
    rd_check("power reset", CCP_ADDR_PWR, 8'h00);
    rd_check("status reset", CCP_ADDR_STS, 8'h00);
    wr(CCP_ADDR_DYN, 8'hfb);
    rd_check("dynamic reserved", CCP_ADDR_DYN, 8'hfb);
    idle(1);
    check4("split clock on", 4'b0001, {3'b000, dynamic_split_clock_sel});
    wr(CCP_ADDR_DYN, 8'h00);
    idle(2);
    check4("split clock off", 4'b0000, {3'b000, dynamic_split_clock_sel});
    wr(CCP_ADDR_PWR, 8'hee);
    rd_check("power reserved", CCP_ADDR_PWR, 8'hee);
    wr(CCP_ADDR_STS, 8'hff);
    rd_check("status read only", CCP_ADDR_STS, 8'h00);
    rd_check("unmapped read", 8'h10, 8'h00);
    for (int i = 0; i < 4; i++) begin
      e = 8'h01 << bits[i];
      wr(CCP_ADDR_PWR, e);
      idle(2);
      check4("bias and detectors", {e[5], e[3], e[2], e[1]},
             {mic_bias_power_on, ultrasound_detect_en, voice_detect_en, ultrasound_detect_alt_en});
    end
    wr(CCP_ADDR_PWR, 8'h00);
    run_path(1'b0);
    run_path(1'b1);
    wrap_up();
  end

  // ****************************************
  // watchdog
  // ****************************************
  // the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    wrap_up();
  end

endmodule : ccp_power_ctrl_tb_top
